// ==== bench/cfg_host.sv ====
// Host model driving the serial configuration port
`timescale 1ns/1ps
module cfg_host (
  // Clock
  input  wire logic clock,
  // Serial pins
  output logic      spi_sck,
  output logic      spi_ss_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  // ======
  // Idle levels: clock stands low outside frames
  initial begin
    spi_sck  = 1'b0;
    spi_ss_n = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // ======
  // One frame: write flag, 9-bit address, 16 data bits, MSB first
  // Four clocks per level, above the 3-clock minimum
  task automatic xfer(input logic wr, input logic [8:0] addr,
                      input logic [15:0] wdata, output logic [15:0] rdata);
    logic [25:0] bits;
    bits     = {wr, addr, wdata};
    rdata    = 16'h0000;
    spi_ss_n = 1'b0;
    for (int k = 25; k >= 0; k--) begin
      spi_mosi = bits[k];
      tick(4);
      if (k < 16) rdata[k] = spi_miso;
      spi_sck = 1'b1;
      tick(4);
      spi_sck = 1'b0;
    end
    tick(4);
    spi_ss_n = 1'b1;
    // Released line flips so a stale bit is never mistaken for data
    spi_mosi = ~spi_mosi;
    tick(2);
  endtask
endmodule

// ==== bench/tb.sv ====
// Testbench for the frame-synchronised configuration bank
`timescale 1ns/1ps
`include "config_defines.svh"
module tb;
  logic        clock, resetn, spi_sck, spi_ss_n, spi_mosi, spi_miso;
  logic        spi_miso_oe, seq_running, frame_start, frame_blank;
  logic        train_data, train_sync, act_subsample_r, act_binning_r;
  logic        black_suspect, sync_suspect_r, test_suspect_r;
  logic [5:0]  op_mode;
  logic [7:0]  act_black_lines_r;
  logic [15:0] act_dummy_lines_r, act_roi_r, act_exposure_r, act_gain_r;
  logic [15:0] rdv;
  int          fail_count, comparisons;

  frame_synced_config_update u_dut (
    .clock, .resetn, .spi_sck, .spi_ss_n, .spi_mosi, .spi_miso,
    .spi_miso_oe, .seq_running, .frame_start, .frame_blank, .train_data,
    .train_sync, .op_mode, .act_subsample_r, .act_binning_r,
    .act_black_lines_r, .act_dummy_lines_r, .act_roi_r, .act_exposure_r,
    .act_gain_r, .black_suspect, .sync_suspect_r, .test_suspect_r);

  cfg_host u_host (.clock, .spi_sck, .spi_ss_n, .spi_mosi, .spi_miso);

  always #5 clock = ~clock;

  // ======
  // Helpers
  task automatic check(input string name, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    u_host.xfer(1'b1, a, d, rdv);
  endtask
  // Returns one cycle after the strobe, once the active set has landed
  task automatic wait_frame;
    int i;
    for (i = 0; i < 1100; i++) begin
      @(posedge clock);
      #1;
      if (frame_start === 1'b1) break;
    end
    if (i == 1100) begin
      fail_count++;
      give_verdict();
    end
    @(posedge clock);
    #1;
  endtask
  task automatic wait_run(input logic v);
    int i;
    for (i = 0; i < 20 && seq_running !== v; i++) @(posedge clock);
    #1;
    check("seq_running", 16'(seq_running), 16'(v));
    // A sequencer that never answers ends the run; the check above counted it
    if (seq_running !== v) give_verdict();
  endtask

  // ======
  // Scenarios
  task automatic t_reset;
    check("running", 16'(seq_running), 16'h0000);
    check("black lines", 16'(act_black_lines_r), 16'h0001);
    check("roi", act_roi_r, 16'h0001);
    check("blank", 16'(frame_blank), 16'h0000);
    u_host.xfer(1'b0, `ADDR_ROI_SEL, 16'h0000, rdv);
    check("roi read", rdv, 16'h0001);
    wr(`ADDR_GAIN, 16'h1234);
    u_host.xfer(1'b0, `ADDR_GAIN, 16'h0000, rdv);
    check("gain read", rdv, 16'h1234);
    u_host.xfer(1'b0, 9'h1ff, 16'h0000, rdv);
    check("unmapped read", rdv, 16'h0000);
    check("miso oe", 16'(spi_miso_oe), 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_enable;
    wr(`ADDR_SEQ_CTRL, 16'h0002);
    check("running", 16'(seq_running), 16'h0000);
    wr(`ADDR_SEQ_CTRL, 16'h0003);
    wait_run(1'b1);
    check("op mode", 16'(op_mode), 16'h0001);
    $display("test enable done");
  endtask
  task automatic t_gain;
    wait_frame();
    wr(`ADDR_GAIN, 16'h00aa);
    check("gain held", act_gain_r, 16'h1234);
    wait_frame();
    check("gain applied", act_gain_r, 16'h00aa);
    $display("test gain done");
  endtask
  task automatic t_black;
    wait_frame();
    wr(`ADDR_BLACK_LINES, 16'h0003);
    check("black suspect", 16'(black_suspect), 16'h0001);
    check("running", 16'(seq_running), 16'h0001);
    check("black held", 16'(act_black_lines_r), 16'h0001);
    wait_frame();
    check("blank", 16'(frame_blank), 16'h0001);
    check("train data", 16'(train_data), 16'h0001);
    check("train sync", 16'(train_sync), 16'h0001);
    check("black lines", 16'(act_black_lines_r), 16'h0003);
    wait_frame();
    check("blank end", 16'(frame_blank), 16'h0000);
    $display("test black lines done");
  endtask
  task automatic t_roi;
    wait_frame();
    wr(`ADDR_SEQ_CTRL, 16'h0383);
    wr(9'h100, 16'h0040);
    wr(`ADDR_ROI_SEL, 16'h0001);
    check("subsample held", 16'(act_subsample_r), 16'h0000);
    check("binning held", 16'(act_binning_r), 16'h0000);
    wait_frame();
    check("no blank", 16'(frame_blank), 16'h0000);
    check("subsample", 16'(act_subsample_r), 16'h0001);
    check("binning", 16'(act_binning_r), 16'h0001);
    wr(`ADDR_ROI_SEL, 16'h0002);
    wait_frame();
    check("roi blank", 16'(frame_blank), 16'h0001);
    check("roi", act_roi_r, 16'h0002);
    $display("test window switch done");
  endtask
  task automatic t_expo;
    wait_frame();
    wr(`ADDR_EXPOSURE, 16'h2055);
    wr(`ADDR_GAIN, 16'h0011);
    wait_frame();
    check("exposure held", act_exposure_r, 16'h0000);
    check("gain delayed", act_gain_r, 16'h00aa);
    wait_frame();
    check("exposure", act_exposure_r, 16'h2055);
    check("gain", act_gain_r, 16'h0011);
    $display("test exposure done");
  endtask
  task automatic t_suspect;
    wait_frame();
    wr(`ADDR_SYNC_BASE, 16'h0abc);
    wr(`ADDR_TEST_BASE, 16'h0001);
    check("sync suspect", 16'(sync_suspect_r), 16'h0001);
    check("test suspect", 16'(test_suspect_r), 16'h0001);
    check("running", 16'(seq_running), 16'h0001);
    wait_frame();
    check("sync clear", 16'(sync_suspect_r), 16'h0000);
    check("test clear", 16'(test_suspect_r), 16'h0000);
    $display("test suspect done");
  endtask
  task automatic t_global;
    wr(`ADDR_SEQ_CTRL, 16'h0000);
    wait_run(1'b0);
    check("blank idle", 16'(frame_blank), 16'h0000);
    // Triggered master global shutter, so exposure sync mode skips the latency
    wr(`ADDR_SEQ_CTRL, 16'h0005);
    wait_run(1'b1);
    wait_frame();
    wr(`ADDR_DUMMY_LINES, 16'h0005);
    wr(`ADDR_EXPOSURE, 16'h4077);
    wait_frame();
    check("global blank", 16'(frame_blank), 16'h0000);
    check("dummy", act_dummy_lines_r, 16'h0005);
    check("exposure fast", act_exposure_r, 16'h4077);
    $display("test global done");
  endtask

  // ======
  // Main sequence; the only reserved address written is 9'h100, in the window switch test
  initial begin
    clock  = 1'b0;
    resetn = 1'b0;
    repeat (5) @(posedge clock);
    #1;
    resetn = 1'b1;
    @(posedge clock);
    #1;
    t_reset();
    t_enable();
    t_gain();
    t_black();
    t_roi();
    t_expo();
    t_suspect();
    t_global();
    give_verdict();
  end
endmodule

// ==== design/cfg_serial_port.sv ====
// Serial configuration port slave: wr flag, 9-bit address, 16-bit data
`timescale 1ns/1ps
`include "config_defines.svh"
module cfg_serial_port (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Serial pins
  input  wire logic        spi_sck,
  input  wire logic        spi_ss_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  // Register side
  output logic             wr_en,
  output logic [8:0]       wr_addr,
  output logic [15:0]      wr_data,
  output logic             rd_en,
  output logic [8:0]       rd_addr,
  input  wire logic [15:0] rd_data
);
  // ==========================================================
  // Edge detect; pins already synchronous to clock
  logic        sck_q_r;
  logic [4:0]  bitcnt_r;
  logic [25:0] shift_r;
  logic [25:0] shift_nxt;
  logic [15:0] tx_r;
  logic        is_read_r;
  logic        load_r;
  logic        rise;
  logic        fall;

  assign rise      = spi_sck & ~sck_q_r & ~spi_ss_n;
  assign fall      = ~spi_sck & sck_q_r & ~spi_ss_n;
  assign shift_nxt = {shift_r[24:0], spi_mosi};

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sck_q_r <= 1'b0;
    end else begin
      sck_q_r <= spi_sck;
    end
  end

  // ==========================================================
  // Receive shifter and header decode
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bitcnt_r  <= 5'h00;
      shift_r   <= 26'h000_0000;
      is_read_r <= 1'b0;
      load_r    <= 1'b0;
      rd_addr   <= 9'h000;
      wr_en     <= 1'b0;
      wr_addr   <= 9'h000;
      wr_data   <= 16'h0000;
    end else begin
      load_r <= 1'b0;
      wr_en  <= 1'b0;
      if (spi_ss_n) begin
        bitcnt_r  <= 5'h00;
        is_read_r <= 1'b0;
      end else if (rise) begin
        shift_r  <= shift_nxt;
        bitcnt_r <= bitcnt_r + 5'h01;
        if (bitcnt_r == 5'h09) begin
          is_read_r <= ~shift_nxt[9];
          load_r    <= ~shift_nxt[9];
          rd_addr   <= shift_nxt[8:0];
        end
        if (bitcnt_r == 5'h19 && shift_nxt[25]) begin
          wr_en   <= 1'b1;
          wr_addr <= shift_nxt[24:16];
          wr_data <= shift_nxt[15:0];
        end
      end
    end
  end

  // ==========================================================
  // Read data shifter, changes on falling sck
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_r <= 16'h0000;
    end else if (load_r) begin
      tx_r <= rd_data;
    end else if (fall && bitcnt_r > 5'h0a) begin
      tx_r <= {tx_r[14:0], 1'b0};
    end
  end

  assign rd_en       = load_r;
  assign spi_miso    = tx_r[15];
  assign spi_miso_oe = ~spi_ss_n & is_read_r;
endmodule

// ==== design/config_defines.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef CONFIG_DEFINES_SVH
`define CONFIG_DEFINES_SVH
// ==========================================================
// Register offsets
`define ADDR_CLK_GEN      9'h020
`define ADDR_IMAGE_CORE   9'h028
`define ADDR_FRONT_END    9'h030
`define ADDR_BIAS_BASE    9'h040
`define ADDR_BIAS_LAST    9'h047
`define ADDR_SER_TX       9'h070
`define ADDR_BLACK_CFG    9'h080
`define ADDR_SYNC_BLACK   9'h081
`define ADDR_SYNC_BASE    9'h082
`define ADDR_SYNC_LAST    9'h087
`define ADDR_TEST_BASE    9'h090
`define ADDR_TEST_LAST    9'h096
`define ADDR_SEQ_CTRL     9'h0c0
`define ADDR_ROI_SEL      9'h0c3
`define ADDR_BLACK_LINES  9'h0c5
`define ADDR_DUMMY_LINES  9'h0c6
`define ADDR_EXPOSURE     9'h0c7
`define ADDR_GAIN         9'h0cc
// ==========================================================
// Field positions
`define BIT_SEQ_EN        0
`define BIT_ROLLING       1
`define BIT_TRIGGERED     2
`define BIT_SLAVE         3
`define BIT_SUBSAMPLE     7
`define BIT_BINNING       8
`define BIT_BLANK_ROI     9
`define BIT_BLACK_ALGO    8
`define BIT_GAIN_LAT_COMP 13
`define BIT_EXP_SYNC_MODE 14
// ==========================================================
// Reset values
`define RST_ZERO          16'h0000
`define RST_SEQ_CTRL      16'h0000
`define RST_ROI_SEL       16'h0001
`define RST_BLACK_LINES   16'h0001
// ==========================================================
// Timing counts
`define FRAME_CYCLES      16'h03e8
`define BLACK_SETTLE      3'h2
`endif

// ==== design/config_pkg.sv ====
// Types shared by the configuration block
package config_pkg;
  typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_t;
endpackage

// ==== design/frame_synced_config_update.sv ====
// Configuration register bank with frame-synchronised update of readout parameters
//
// Summary of operation
// - Enable bit starts acquisition, clear returns idle
// - Black-level writes flag transient bad frames
// - Sync code writes flag current frame suspect
// - Test pattern writes flag one transient frame
// - Artifact-prone writes never stop acquisition
// - Frame parameters change only at frame boundary while running; idle follows the shadow at once
// - Blanked frame sends training on both channels
// - Subsampling and binning apply at next frame
// - Line count change blanks one rolling frame
// - Window switch blanks one rolling frame if enabled
// - Only different active window counts as switch
// - Active window resize never causes blanking
// - Exposure has one frame latency unless fast
// - Gain applies at start of next frame
// - Gain latency compensation adds one frame
`timescale 1ns/1ps
`include "config_defines.svh"
module frame_synced_config_update
  import config_pkg::*;
(
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   resetn,
  // Serial configuration port
  input  wire logic   spi_sck,
  input  wire logic   spi_ss_n,
  input  wire logic   spi_mosi,
  output logic        spi_miso,
  output logic        spi_miso_oe,
  // Sequencer status
  output logic        seq_running,
  output logic        frame_start,
  output logic        frame_blank,
  output logic        train_data,
  output logic        train_sync,
  output logic [5:0]  op_mode,
  // Active readout set
  output logic        act_subsample_r,
  output logic        act_binning_r,
  output logic [7:0]  act_black_lines_r,
  output logic [15:0] act_dummy_lines_r,
  output logic [15:0] act_roi_r,
  output logic [15:0] act_exposure_r,
  output logic [15:0] act_gain_r,
  // Transient artifact indications
  output logic        black_suspect,
  output logic        sync_suspect_r,
  output logic        test_suspect_r
);
  // ==========================================================
  // Serial port
  logic        wr_en;
  logic [8:0]  wr_addr;
  logic [15:0] wr_data;
  logic [8:0]  rd_addr;
  logic [15:0] rd_data;
  cfg_serial_port u_port (
    .clock       (clock),
    .resetn      (resetn),
    .spi_sck     (spi_sck),
    .spi_ss_n    (spi_ss_n),
    .spi_mosi    (spi_mosi),
    .spi_miso    (spi_miso),
    .spi_miso_oe (spi_miso_oe),
    .wr_en       (wr_en),
    .wr_addr     (wr_addr),
    .wr_data     (wr_data),
    .rd_en       (),
    .rd_addr     (rd_addr),
    .rd_data     (rd_data)
  );
  // ==========================================================
  // Host-visible registers
  logic [15:0] clk_gen_r;
  logic [15:0] core_r;
  logic [15:0] afe_r;
  logic [15:0] ser_tx_r;
  logic [15:0] black_cfg_r;
  logic [15:0] sync_black_r;
  logic [15:0] seq_ctrl_r;
  logic [15:0] roi_sel_r;
  logic [15:0] black_lines_r;
  logic [15:0] dummy_lines_r;
  logic [15:0] exposure_r;
  logic [15:0] gain_r;
  logic [15:0] bias_r [8];
  logic [15:0] sync_code_r [6];
  logic [15:0] test_cfg_r [7];
  logic wr_bias;
  logic wr_sync;
  logic wr_test;
  logic wr_black;
  assign wr_bias  = wr_en && wr_addr >= `ADDR_BIAS_BASE && wr_addr <= `ADDR_BIAS_LAST;
  assign wr_sync  = wr_en && (wr_addr == `ADDR_SYNC_BLACK ||
                    (wr_addr >= `ADDR_SYNC_BASE && wr_addr <= `ADDR_SYNC_LAST));
  assign wr_test  = wr_en && wr_addr >= `ADDR_TEST_BASE && wr_addr <= `ADDR_TEST_LAST;
  assign wr_black = wr_en && (wr_addr == `ADDR_BLACK_CFG || wr_addr == `ADDR_SYNC_BLACK ||
                    wr_addr == `ADDR_BLACK_LINES);
  // Static registers are stored as written; keeping them still while running is the host's job
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      clk_gen_r     <= `RST_ZERO;
      core_r        <= `RST_ZERO;
      afe_r         <= `RST_ZERO;
      ser_tx_r      <= `RST_ZERO;
      black_cfg_r   <= `RST_ZERO;
      sync_black_r  <= `RST_ZERO;
      seq_ctrl_r    <= `RST_SEQ_CTRL;
      roi_sel_r     <= `RST_ROI_SEL;
      black_lines_r <= `RST_BLACK_LINES;
      dummy_lines_r <= `RST_ZERO;
      exposure_r    <= `RST_ZERO;
      gain_r        <= `RST_ZERO;
      for (int i = 0; i < 8; i++) begin
        bias_r[i] <= `RST_ZERO;
      end
      for (int i = 0; i < 6; i++) begin
        sync_code_r[i] <= `RST_ZERO;
      end
      for (int i = 0; i < 7; i++) begin
        test_cfg_r[i] <= `RST_ZERO;
      end
    end else if (wr_en) begin
      case (wr_addr)
        `ADDR_CLK_GEN:     clk_gen_r     <= wr_data;
        `ADDR_IMAGE_CORE:  core_r        <= wr_data;
        `ADDR_FRONT_END:   afe_r         <= wr_data;
        `ADDR_SER_TX:      ser_tx_r      <= wr_data;
        `ADDR_BLACK_CFG:   black_cfg_r   <= wr_data;
        `ADDR_SYNC_BLACK:  sync_black_r  <= wr_data;
        `ADDR_SEQ_CTRL:    seq_ctrl_r    <= wr_data;
        `ADDR_ROI_SEL:     roi_sel_r     <= wr_data;
        `ADDR_BLACK_LINES: black_lines_r <= wr_data;
        `ADDR_DUMMY_LINES: dummy_lines_r <= wr_data;
        `ADDR_EXPOSURE:    exposure_r    <= wr_data;
        `ADDR_GAIN:        gain_r        <= wr_data;
        default: begin
          if (wr_bias) begin
            bias_r[wr_addr[2:0]] <= wr_data;
          end
          if (wr_sync && wr_addr != `ADDR_SYNC_BLACK) begin
            sync_code_r[3'(wr_addr - `ADDR_SYNC_BASE)] <= wr_data;
          end
          if (wr_test) begin
            test_cfg_r[3'(wr_addr - `ADDR_TEST_BASE)] <= wr_data;
          end
        end
      endcase
    end
  end
  // ==========================================================
  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_data = 16'h0000;
    case (rd_addr)
      `ADDR_CLK_GEN:     rd_data = clk_gen_r;
      `ADDR_IMAGE_CORE:  rd_data = core_r;
      `ADDR_FRONT_END:   rd_data = afe_r;
      `ADDR_SER_TX:      rd_data = ser_tx_r;
      `ADDR_BLACK_CFG:   rd_data = black_cfg_r;
      `ADDR_SYNC_BLACK:  rd_data = sync_black_r;
      `ADDR_SEQ_CTRL:    rd_data = seq_ctrl_r;
      `ADDR_ROI_SEL:     rd_data = roi_sel_r;
      `ADDR_BLACK_LINES: rd_data = black_lines_r;
      `ADDR_DUMMY_LINES: rd_data = dummy_lines_r;
      `ADDR_EXPOSURE:    rd_data = exposure_r;
      `ADDR_GAIN:        rd_data = gain_r;
      default: begin
        if (rd_addr >= `ADDR_BIAS_BASE && rd_addr <= `ADDR_BIAS_LAST) begin
          rd_data = bias_r[rd_addr[2:0]];
        end else if (rd_addr >= `ADDR_SYNC_BASE && rd_addr <= `ADDR_SYNC_LAST) begin
          rd_data = sync_code_r[3'(rd_addr - `ADDR_SYNC_BASE)];
        end else if (rd_addr >= `ADDR_TEST_BASE && rd_addr <= `ADDR_TEST_LAST) begin
          rd_data = test_cfg_r[3'(rd_addr - `ADDR_TEST_BASE)];
        end
      end
    endcase
  end
  // ==========================================================
  // Frame sequencer
  seq_state_t  state_r;
  logic [15:0] fcnt_r;
  logic        rolling;
  logic        commit;

  assign rolling     = seq_ctrl_r[`BIT_ROLLING];
  assign seq_running = (state_r == SEQ_RUN);
  assign frame_start = seq_running && fcnt_r == 16'h0000;
  assign op_mode     = seq_ctrl_r[6:1];
  // Idle has no frames, so the active set simply follows the shadow
  assign commit      = frame_start || !seq_running;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= SEQ_IDLE;
      fcnt_r  <= 16'h0000;
    end else begin
      case (state_r)
        SEQ_IDLE: begin
          fcnt_r <= 16'h0000;
          if (seq_ctrl_r[`BIT_SEQ_EN]) begin
            state_r <= SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          fcnt_r <= (fcnt_r == `FRAME_CYCLES - 16'h0001) ? 16'h0000 : fcnt_r + 16'h0001;
          if (!seq_ctrl_r[`BIT_SEQ_EN]) begin
            state_r <= SEQ_IDLE;
            fcnt_r  <= 16'h0000;
          end
        end
        default: state_r <= SEQ_IDLE;
      endcase
    end
  end
  // ==========================================================
  // Active set, copied from shadow at frame start
  logic [15:0] exp_stage_r;
  logic [15:0] gain_stage_r;
  logic        exp_fast;
  logic        gain_lat;

  // Triggered master global shutter with sync mode skips the extra stage
  assign exp_fast = exposure_r[`BIT_EXP_SYNC_MODE] && seq_ctrl_r[`BIT_TRIGGERED] &&
                    !seq_ctrl_r[`BIT_SLAVE] && !rolling;
  assign gain_lat = exposure_r[`BIT_GAIN_LAT_COMP];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      act_subsample_r   <= 1'b0;
      act_binning_r     <= 1'b0;
      act_black_lines_r <= 8'(`RST_BLACK_LINES);
      act_dummy_lines_r <= `RST_ZERO;
      act_roi_r         <= `RST_ROI_SEL;
      exp_stage_r       <= `RST_ZERO;
      act_exposure_r    <= `RST_ZERO;
      gain_stage_r      <= `RST_ZERO;
      act_gain_r        <= `RST_ZERO;
    end else if (commit) begin
      act_subsample_r   <= seq_ctrl_r[`BIT_SUBSAMPLE];
      act_binning_r     <= seq_ctrl_r[`BIT_BINNING];
      act_black_lines_r <= black_lines_r[7:0];
      act_dummy_lines_r <= dummy_lines_r;
      act_roi_r         <= roi_sel_r;
      exp_stage_r       <= exposure_r;
      act_exposure_r    <= exp_fast ? exposure_r : exp_stage_r;
      gain_stage_r      <= gain_r;
      act_gain_r        <= gain_lat ? gain_stage_r : gain_r;
    end
  end
  // ==========================================================
  // Blanking decision
  logic roi_pend_r;
  logic blank_r;
  logic line_change;

  // Writes repeating the active window are not switches
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      roi_pend_r <= 1'b0;
    end else if (wr_en && wr_addr == `ADDR_ROI_SEL && wr_data != roi_sel_r) begin
      roi_pend_r <= 1'b1;
    end else if (commit) begin
      roi_pend_r <= 1'b0;
    end
  end

  assign line_change = black_lines_r[7:0] != act_black_lines_r ||
                       dummy_lines_r != act_dummy_lines_r;

  // Window geometry writes are not looked at, so a resize never blanks
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      blank_r <= 1'b0;
    end else if (frame_start) begin
      blank_r <= rolling && (line_change ||
                 (roi_pend_r && seq_ctrl_r[`BIT_BLANK_ROI]));
    end else if (!seq_running) begin
      blank_r <= 1'b0;
    end
  end

  assign frame_blank = blank_r;
  assign train_data  = blank_r;
  assign train_sync  = blank_r;
  // ==========================================================
  // Artifact indications; acquisition continues throughout
  logic [2:0] black_cnt_r;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      black_cnt_r <= 3'h0;
    end else if (wr_black && seq_running) begin
      black_cnt_r <= `BLACK_SETTLE;
    end else if (frame_start && black_cnt_r != 3'h0) begin
      black_cnt_r <= black_cnt_r - 3'h1;
    end
  end

  assign black_suspect = black_cnt_r != 3'h0;

  // Set wins over the frame-start clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync_suspect_r <= 1'b0;
    end else if (wr_sync && seq_running) begin
      sync_suspect_r <= 1'b1;
    end else if (frame_start || !seq_running) begin
      sync_suspect_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      test_suspect_r <= 1'b0;
    end else if (wr_test && seq_running) begin
      test_suspect_r <= 1'b1;
    end else if (frame_start || !seq_running) begin
      test_suspect_r <= 1'b0;
    end
  end
  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_seq_start: assert property (
    (wr_en && wr_addr == `ADDR_SEQ_CTRL && wr_data[0]) |-> ##2 seq_running)
    else $error("sequencer did not start");
  a_seq_stop: assert property (
    (wr_en && wr_addr == `ADDR_SEQ_CTRL && !wr_data[0]) |-> ##2 !seq_running)
    else $error("sequencer did not stop");
  a_keep_running: assert property (
    (seq_running && (wr_black || wr_sync || wr_test)) |=> seq_running)
    else $error("artifact write stopped acquisition");
  a_defer_subsample: assert property (
    (seq_running && !frame_start) |=> $stable(act_subsample_r) && $stable(act_roi_r))
    else $error("readout parameter changed mid frame");
  a_gain_commit: assert property (
    (frame_start && !gain_lat) |=> act_gain_r == $past(gain_r))
    else $error("gain not applied at frame start");
  a_gain_latcomp: assert property (
    (frame_start && gain_lat) |=> act_gain_r == $past(gain_stage_r))
    else $error("gain latency compensation wrong");
  a_exp_latency: assert property (
    (frame_start && !exp_fast) |=> act_exposure_r == $past(exp_stage_r))
    else $error("exposure latency wrong");
  a_blank_lines: assert property (
    (frame_start && rolling && line_change) |=> frame_blank && train_sync)
    else $error("line change did not blank");
  a_no_blank_global: assert property (
    (frame_start && !rolling) |=> !frame_blank)
    else $error("blanking in global shutter");
  a_roi_detect: assert property (
    (wr_en && wr_addr == `ADDR_ROI_SEL && wr_data == roi_sel_r && !roi_pend_r) |=> !roi_pend_r)
    else $error("same window flagged as switch");
  a_sync_flag: assert property (
    (wr_sync && seq_running) |=> sync_suspect_r [*1] ##0 seq_running)
    else $error("sync code write not flagged");
endmodule
